// [src/etc_defines.svh]
`ifndef ETC_DEFINES_SVH
`define ETC_DEFINES_SVH
// =====================================================================
// Register byte offsets.
`define ETC_OFF_BUSY_LO 12'h000
`define ETC_OFF_BUSY_HI 12'h004
`define ETC_OFF_FLAGS_LO 12'h008
`define ETC_OFF_FLAGS_HI 12'h00c
`define ETC_OFF_SAVE_LO 12'h010
`define ETC_OFF_SAVE_HI 12'h014
`define ETC_OFF_CUR_IDX 12'h018
`define ETC_OFF_FRM_CNT 12'h01c
`define ETC_OFF_ENTRY_LO 12'h020
`define ETC_OFF_ENTRY_HI 12'h024
`define ETC_OFF_AEP_LO 12'h028
`define ETC_OFF_AEP_HI 12'h02c
`define ETC_OFF_FS_LO 12'h030
`define ETC_OFF_FS_HI 12'h034
`define ETC_OFF_GS_LO 12'h038
`define ETC_OFF_GS_HI 12'h03c
`define ETC_OFF_FS_LIM 12'h040
`define ETC_OFF_GS_LIM 12'h044
`define ETC_OFF_EXT_SEL 12'h048
`define ETC_OFF_CONTAINER_LO 12'h04c
`define ETC_OFF_CONTAINER_HI 12'h050
`define ETC_OFF_FRAME_SIZE 12'h054
// =====================================================================
// Field positions and sizes.
`define ETC_BIT_FAULT_DETAIL 0
`define ETC_BIT_DEBUG_OPT_IN 0
`define ETC_PAGE_MASK 64'h0000_0000_0000_0fff
`define ETC_MISC_FAULT_BYTES 16'h0010
`define ETC_RST_ZERO 64'h0
`define ETC_RST_FRM_CNT 32'h0000_0001
`define ETC_RST_FRAME_SIZE 32'h0000_1000
`endif

// [src/etc_pkg.sv]
package etc_pkg;
	typedef enum logic [1:0] {
		ETC_BUS_IDLE,
		ETC_BUS_DATA
	} etc_bus_e;
	typedef enum logic [2:0] {
		ETC_OP_NONE,
		ETC_OP_ENTER,
		ETC_OP_RESUME,
		ETC_OP_AEX,
		ETC_OP_EXIT,
		ETC_OP_PAGE_ADD,
		ETC_OP_PAGE_ACCEPT
	} etc_op_e;
endpackage

// [src/etc_misc_size.sv]
`timescale 1ns/1ps
`include "etc_defines.svh"
// =====================================================================
// Miscellaneous region size from the select vector; only bit 0 is defined.
module etc_misc_size (
	// Select vector
	input wire logic [31:0] i_sel,
	// Region size and save mask
	output logic [15:0] o_bytes,
	output logic o_save_fault
);
	always_comb begin
		o_save_fault = i_sel[`ETC_BIT_FAULT_DETAIL]; // [R2]
		o_bytes = o_save_fault ? `ETC_MISC_FAULT_BYTES : 16'h0000; // [R4]
	end
endmodule

// [src/etc_thread_ctl.sv]
`timescale 1ns/1ps
`include "etc_defines.svh"
// =====================================================================
// How it works
// R1: Software zeroes the select vector when enumeration reports no extras.
// R2: Async exit saves only the extended information selected.
// R3: Select bit 0 enables fault details; bits 31:1 read zero.
// R4: Miscellaneous region size follows the select vector.
// R5: Software places each thread structure on a 4 KiB boundary.
// R6: Busy state is 0 when free, 1 while executing.
// R7: Page add or accept clears the current frame index.
// R8: Index increments on async exit, decrements on resume.
// R9: Index selects the frame at save-area offset receiving state.
// R10: Enter fails unless index is below frame count.
// R11: Software keeps the save-area offset page aligned.
// R12: FS/GS bases are container base plus offsets, page aligned.
// R13: FS/GS limits load from the limit fields on entry.
// R14: Enter jumps to container base plus entry offset.
// R15: Enter records the async exit pointer.
// R16: Flags bit 0 is debug opt-in, cleared on page add.
// R17: Debugger sets opt-in only with container debug attribute.
// R18: Async exit stores state in the frame the index selects.
// R19: Software places every save frame page aligned.
// R20: Entry refused while busy; busy set on entry, cleared on leave.
module etc_thread_ctl #(
	parameter int IDX_W = 32
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// AHB-Lite slave
	input wire logic i_hsel,
	input wire logic [11:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	// Core events
	input wire logic i_op_valid,
	input wire logic [2:0] i_op,
	input wire logic [63:0] i_aep,
	input wire logic i_debug_attr,
	// Results
	output logic o_op_done,
	output logic o_op_fail,
	output logic [63:0] o_target_ip,
	output logic [63:0] o_fs_base,
	output logic [63:0] o_gs_base,
	output logic [31:0] o_fs_limit,
	output logic [31:0] o_gs_limit,
	output logic [63:0] o_frame_addr,
	output logic o_save_fault,
	output logic [15:0] o_misc_bytes,
	output logic o_debug_en,
	output logic o_busy
);
	typedef struct packed {
		etc_pkg::etc_bus_e bus;
		logic [11:0] addr;
		logic wr;
		logic [31:0] rdata;
		logic busy;
		logic dbg;
		logic [63:0] save_off;
		logic [IDX_W-1:0] cur;
		logic [IDX_W-1:0] cnt;
		logic [63:0] entry;
		logic [63:0] async_exit_pointer;
		logic [63:0] fs_off;
		logic [63:0] gs_off;
		logic [31:0] fs_lim;
		logic [31:0] gs_lim;
		logic sel0;
		logic [63:0] base;
		logic [31:0] fsize;
		logic done;
		logic fail;
		logic [63:0] tip;
		logic [63:0] fsb;
		logic [63:0] gsb;
		logic [31:0] fsl;
		logic [31:0] gsl;
		logic [63:0] faddr;
	} etc_state_s;

	etc_state_s st_ff;
	etc_state_s nxt_st;
	logic [15:0] misc_bytes;
	logic save_fault;
	logic [31:0] sel_word;
	logic enter_ok;
	logic [63:0] cur_frame;

	assign sel_word = {31'h0, st_ff.sel0}; // [R3]

	etc_misc_size u_misc (
		.i_sel(sel_word),
		.o_bytes(misc_bytes),
		.o_save_fault(save_fault)
	);

	// Frame address: container base + save area offset + index * size.
	assign cur_frame = st_ff.base + st_ff.save_off +
		64'(st_ff.cur) * 64'(st_ff.fsize); // [R9] [R18]
	assign enter_ok = !st_ff.busy && (st_ff.cur < st_ff.cnt); // [R10] [R20]

	// =====================================================================
	// Read mux.
	function automatic logic [31:0] rd_word(input etc_state_s s,
			input logic [11:0] a);
		logic [31:0] r;
		r = 32'h0;
		case (a)
			`ETC_OFF_BUSY_LO: r = {31'h0, s.busy}; // [R6]
			`ETC_OFF_FLAGS_LO: r = {31'h0, s.dbg};
			`ETC_OFF_SAVE_LO: r = s.save_off[31:0];
			`ETC_OFF_SAVE_HI: r = s.save_off[63:32];
			`ETC_OFF_CUR_IDX: r = 32'(s.cur);
			`ETC_OFF_FRM_CNT: r = 32'(s.cnt);
			`ETC_OFF_ENTRY_LO: r = s.entry[31:0];
			`ETC_OFF_ENTRY_HI: r = s.entry[63:32];
			`ETC_OFF_AEP_LO: r = s.async_exit_pointer[31:0];
			`ETC_OFF_AEP_HI: r = s.async_exit_pointer[63:32];
			`ETC_OFF_FS_LO: r = s.fs_off[31:0];
			`ETC_OFF_FS_HI: r = s.fs_off[63:32];
			`ETC_OFF_GS_LO: r = s.gs_off[31:0];
			`ETC_OFF_GS_HI: r = s.gs_off[63:32];
			`ETC_OFF_FS_LIM: r = s.fs_lim;
			`ETC_OFF_GS_LIM: r = s.gs_lim;
			`ETC_OFF_EXT_SEL: r = {31'h0, s.sel0}; // [R3]
			`ETC_OFF_CONTAINER_LO: r = s.base[31:0];
			`ETC_OFF_CONTAINER_HI: r = s.base[63:32];
			`ETC_OFF_FRAME_SIZE: r = s.fsize;
			default: r = 32'h0;
		endcase
		return r;
	endfunction

	// =====================================================================
	// Next state.
	always_comb begin
		nxt_st = st_ff;
		nxt_st.done = 1'b0;
		nxt_st.fail = 1'b0;
		// Bus data phase: writes complete here, slave never waits.
		if (st_ff.bus == etc_pkg::ETC_BUS_DATA && st_ff.wr) begin
			case (st_ff.addr)
				`ETC_OFF_FLAGS_LO: begin
					// Opt-in writes land only while the debug attribute is set.
					if (i_debug_attr) begin
						nxt_st.dbg = i_hwdata[`ETC_BIT_DEBUG_OPT_IN];
					end
				end
				`ETC_OFF_SAVE_LO: nxt_st.save_off[31:0] = i_hwdata;
				`ETC_OFF_SAVE_HI: nxt_st.save_off[63:32] = i_hwdata;
				`ETC_OFF_FRM_CNT: nxt_st.cnt = IDX_W'(i_hwdata);
				`ETC_OFF_ENTRY_LO: nxt_st.entry[31:0] = i_hwdata;
				`ETC_OFF_ENTRY_HI: nxt_st.entry[63:32] = i_hwdata;
				`ETC_OFF_FS_LO: nxt_st.fs_off[31:0] = i_hwdata;
				`ETC_OFF_FS_HI: nxt_st.fs_off[63:32] = i_hwdata;
				`ETC_OFF_GS_LO: nxt_st.gs_off[31:0] = i_hwdata;
				`ETC_OFF_GS_HI: nxt_st.gs_off[63:32] = i_hwdata;
				`ETC_OFF_FS_LIM: nxt_st.fs_lim = i_hwdata;
				`ETC_OFF_GS_LIM: nxt_st.gs_lim = i_hwdata;
				// Upper select bits are reserved and are not stored.
				`ETC_OFF_EXT_SEL: nxt_st.sel0 = i_hwdata[0]; // [R3]
				`ETC_OFF_CONTAINER_LO: nxt_st.base[31:0] = i_hwdata;
				`ETC_OFF_CONTAINER_HI: nxt_st.base[63:32] = i_hwdata;
				`ETC_OFF_FRAME_SIZE: nxt_st.fsize = i_hwdata;
				default: nxt_st.fsize = st_ff.fsize;
			endcase
		end
		// Address phase.
		nxt_st.bus = etc_pkg::ETC_BUS_IDLE;
		if (i_hsel && i_hready && i_htrans[1]) begin
			nxt_st.bus = etc_pkg::ETC_BUS_DATA;
			nxt_st.addr = {i_haddr[11:2], 2'b00};
			nxt_st.wr = i_hwrite;
			// Read past a pending write so a pipelined read is not stale.
			nxt_st.rdata = rd_word(nxt_st, {i_haddr[11:2], 2'b00});
		end
		// Core events take priority over a same-cycle bus write.
		if (i_op_valid) begin
			nxt_st.done = 1'b1;
			case (etc_pkg::etc_op_e'(i_op))
				etc_pkg::ETC_OP_ENTER: begin
					if (enter_ok) begin
						nxt_st.busy = 1'b1; // [R20] [R6]
						nxt_st.async_exit_pointer = i_aep; // [R15]
						nxt_st.tip = st_ff.base + st_ff.entry; // [R14]
						nxt_st.fsb = st_ff.base + st_ff.fs_off; // [R12]
						nxt_st.gsb = st_ff.base + st_ff.gs_off; // [R12]
						nxt_st.fsl = st_ff.fs_lim; // [R13]
						nxt_st.gsl = st_ff.gs_lim; // [R13]
					end else begin
						nxt_st.fail = 1'b1; // [R10] [R20]
					end
				end
				etc_pkg::ETC_OP_RESUME: begin
					if (enter_ok && st_ff.cur != '0) begin
						nxt_st.cur = st_ff.cur - IDX_W'(1); // [R8]
						nxt_st.busy = 1'b1; // [R20]
						nxt_st.tip = st_ff.base + st_ff.entry;
					end else begin
						nxt_st.fail = 1'b1;
					end
				end
				etc_pkg::ETC_OP_AEX: begin
					if (st_ff.busy) begin
						nxt_st.faddr = cur_frame; // [R18] [R9]
						nxt_st.cur = st_ff.cur + IDX_W'(1); // [R8]
						nxt_st.busy = 1'b0; // [R20]
						nxt_st.tip = st_ff.async_exit_pointer;
					end else begin
						nxt_st.fail = 1'b1;
					end
				end
				etc_pkg::ETC_OP_EXIT: begin
					nxt_st.busy = 1'b0; // [R20] [R6]
				end
				etc_pkg::ETC_OP_PAGE_ADD: begin
					nxt_st.cur = '0; // [R7]
					nxt_st.dbg = 1'b0; // [R16]
					nxt_st.busy = 1'b0;
				end
				etc_pkg::ETC_OP_PAGE_ACCEPT: begin
					nxt_st.cur = '0; // [R7]
				end
				default: nxt_st.done = 1'b0;
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_ff <= '0;
			st_ff.cnt <= IDX_W'(`ETC_RST_FRM_CNT);
			st_ff.fsize <= `ETC_RST_FRAME_SIZE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Misc size and save mask are registered so outputs leave flops.
	logic [15:0] misc_ff;
	logic save_ff;
	logic dbg_en_ff;
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			misc_ff <= 16'h0;
			save_ff <= 1'b0;
			dbg_en_ff <= 1'b0;
		end else begin
			misc_ff <= misc_bytes; // [R4]
			save_ff <= save_fault; // [R2]
			dbg_en_ff <= nxt_st.dbg & nxt_st.busy; // [R16]
		end
	end

	// =====================================================================
	// Outputs.
	assign o_hrdata = st_ff.rdata;
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;
	assign o_op_done = st_ff.done;
	assign o_op_fail = st_ff.fail;
	assign o_target_ip = st_ff.tip;
	assign o_fs_base = st_ff.fsb;
	assign o_gs_base = st_ff.gsb;
	assign o_fs_limit = st_ff.fsl;
	assign o_gs_limit = st_ff.gsl;
	assign o_frame_addr = st_ff.faddr;
	assign o_save_fault = save_ff;
	assign o_misc_bytes = misc_ff;
	// Debug opt-in only takes effect while running on this structure.
	assign o_debug_en = dbg_en_ff; // [R16]
	assign o_busy = st_ff.busy;

	// =====================================================================
	// Checks.
	wire op_enter = i_op_valid && i_op == 3'(etc_pkg::ETC_OP_ENTER);
	wire op_aex = i_op_valid && i_op == 3'(etc_pkg::ETC_OP_AEX);
	wire op_res = i_op_valid && i_op == 3'(etc_pkg::ETC_OP_RESUME);
	wire op_pg = i_op_valid && (i_op == 3'(etc_pkg::ETC_OP_PAGE_ADD) ||
		i_op == 3'(etc_pkg::ETC_OP_PAGE_ACCEPT));

	enter_refused_a: assert property (@(posedge i_clk) // [R10]
		disable iff (i_rst)
		op_enter && !(st_ff.cur < st_ff.cnt) |=>
		o_op_fail && o_busy == $past(o_busy))
		else $error("enter accepted with no free frame");
	busy_refuse_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R20]
		op_enter && st_ff.busy |=> o_op_fail)
		else $error("enter accepted while busy");
	enter_target_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R14]
		op_enter && enter_ok |=>
		o_target_ip == $past(st_ff.base) + $past(st_ff.entry) && o_busy)
		else $error("enter target wrong");
	aex_index_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R8]
		op_aex && st_ff.busy |=> st_ff.cur == $past(st_ff.cur) + IDX_W'(1))
		else $error("index not incremented on exit");
	resume_index_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R8]
		op_res && enter_ok && st_ff.cur != '0 |=>
		st_ff.cur == $past(st_ff.cur) - IDX_W'(1))
		else $error("index not decremented on resume");
	page_clear_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R7]
		op_pg |=> st_ff.cur == '0)
		else $error("index not cleared by page op");
	frame_addr_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R18]
		op_aex && st_ff.busy |=> o_frame_addr == $past(cur_frame) && !o_busy)
		else $error("frame address wrong");
	aep_saved_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R15]
		op_enter && enter_ok |=> st_ff.async_exit_pointer == $past(i_aep))
		else $error("exit pointer not recorded");
	misc_size_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R4]
		st_ff.sel0 && $stable(st_ff.sel0) |=> o_misc_bytes == `ETC_MISC_FAULT_BYTES)
		else $error("misc size ignores select");
	fs_base_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R12]
		op_enter && enter_ok |=> o_fs_base == $past(st_ff.base + st_ff.fs_off))
		else $error("fs base wrong");
	gs_base_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R12]
		op_enter && enter_ok |=> o_gs_base == $past(st_ff.base + st_ff.gs_off))
		else $error("gs base wrong");
	limits_load_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R13]
		op_enter && enter_ok |=> o_fs_limit == $past(st_ff.fs_lim) &&
		o_gs_limit == $past(st_ff.gs_lim))
		else $error("segment limits not loaded");
	misc_zero_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R4]
		!st_ff.sel0 && $stable(st_ff.sel0) |=> o_misc_bytes == 16'h0)
		else $error("misc size present without select");
	save_mask_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R2]
		1'b1 |=> o_save_fault == $past(st_ff.sel0))
		else $error("save mask does not follow select");
	page_dbg_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R16]
		i_op_valid && i_op == 3'(etc_pkg::ETC_OP_PAGE_ADD) |=> !st_ff.dbg)
		else $error("opt-in not cleared by page add");
	resume_zero_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R8]
		op_res && st_ff.cur == '0 |=> o_op_fail && st_ff.cur == '0)
		else $error("resume accepted at index zero");
	debug_busy_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R16]
		o_debug_en |-> o_busy && st_ff.dbg)
		else $error("debug enabled outside the thread");
	enter_c: cover property (@(posedge i_clk) op_enter && enter_ok);
	page_op_c: cover property (@(posedge i_clk) op_pg);
	aex_resume_c: cover property (@(posedge i_clk) op_aex ##[1:20] op_res);
	refused_c: cover property (@(posedge i_clk) o_op_fail);
endmodule

// [tb/etc_sw_model.sv]
`timescale 1ns/1ps
// =====================================================================
// Software side: builds the thread structure with single word transfers.
module etc_sw_model (
	// Bus clock
	input wire logic i_clk,
	// AHB-Lite master
	input wire logic i_hready,
	input wire logic [31:0] i_hrdata,
	output logic [11:0] o_haddr,
	output logic [1:0] o_htrans,
	output logic o_hwrite,
	output logic [2:0] o_hsize,
	output logic [31:0] o_hwdata,
	// Status
	output logic o_timeout
);
	initial begin
		o_haddr = 12'h0;
		o_htrans = 2'h0;
		o_hwrite = 1'b0;
		o_hsize = 3'h2;
		o_hwdata = 32'h0;
		o_timeout = 1'b0;
	end
	// Called just after a rising edge; returns at the edge that ends
	// the data phase, so transfers may follow back to back.
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		o_haddr <= a;
		o_hwrite <= w;
		o_htrans <= 2'h2;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (i_hready !== 1'b1 && n < 16);
		if (i_hready !== 1'b1) begin
			o_timeout <= 1'b1;
		end
		o_htrans <= 2'h0;
		// A read data phase carries the inverse so stale data never matches.
		o_hwdata <= w ? d : ~o_hwdata;
		do begin
			@(posedge i_clk);
			n++;
		end while (i_hready !== 1'b1 && n < 32);
		q = i_hrdata;
		if (i_hready !== 1'b1) begin
			o_timeout <= 1'b1;
		end
	endtask
endmodule

// [tb/enclave_thread_control_state_bench.sv]
`timescale 1ns/1ps
`include "etc_defines.svh"
// =====================================================================
// Bench: reset values first, then register rows, event sequences and a second reset.
module enclave_thread_control_state_bench;
	typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] e;} etc_row_s;
	etc_row_s rows [14];
	logic i_clk, i_rst, i_op_valid, hsel, attr;
	logic [2:0] i_op;
	logic [63:0] i_aep;
	logic [31:0] hrdata, hwdata;
	logic [11:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic hreadyout, hresp, hwrite, to, done, fail, save_f, dbg, busy;
	logic [63:0] tip, fsb, gsb, frm;
	logic [31:0] fsl, gsl;
	logic [15:0] misc;
	int mismatches, n_checks;
	etc_thread_ctl u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_hsel(hsel),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
		.i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hreadyout),
		.o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
		.i_op_valid(i_op_valid), .i_op(i_op), .i_aep(i_aep),
		.i_debug_attr(attr), .o_op_done(done), .o_op_fail(fail),
		.o_target_ip(tip), .o_fs_base(fsb), .o_gs_base(gsb),
		.o_fs_limit(fsl), .o_gs_limit(gsl), .o_frame_addr(frm),
		.o_save_fault(save_f), .o_misc_bytes(misc), .o_debug_en(dbg),
		.o_busy(busy));
	etc_sw_model u_sw (.i_clk(i_clk), .i_hready(hreadyout),
		.i_hrdata(hrdata), .o_haddr(haddr), .o_htrans(htrans),
		.o_hwrite(hwrite), .o_hsize(hsize), .o_hwdata(hwdata),
		.o_timeout(to));
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end
	task automatic stop_test();
		if (to !== 1'b0) begin
			mismatches++;
		end
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string s, input logic [63:0] e,
		input logic [63:0] g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		u_sw.xfer(1'b1, a, d, q);
	endtask
	task automatic rdc(input string s, input logic [11:0] a,
		input logic [31:0] e);
		logic [31:0] q;
		u_sw.xfer(1'b0, a, 32'h0, q);
		chk(s, {32'h0, e}, {32'h0, q});
	endtask
	// The answer stands for one cycle only, so it is sampled right then.
	task automatic op(input logic [2:0] c, input logic f);
		i_op <= c;
		i_op_valid <= 1'b1;
		@(posedge i_clk);
		i_op_valid <= 1'b0;
		#1;
		chk("op done", 64'h1, {63'h0, done});
		chk("op fail", {63'h0, f}, {63'h0, fail});
		@(posedge i_clk);
	endtask
	initial begin
		i_rst = 1'b1;
		i_op_valid = 1'b0;
		i_op = 3'h0;
		i_aep = 64'h0;
		hsel = 1'b1;
		attr = 1'b1;
		rows = '{
			'{`ETC_OFF_EXT_SEL, 32'hffff_ffff, 32'h1},
			'{`ETC_OFF_SAVE_LO, 32'h2000, 32'h2000},
			'{`ETC_OFF_FRM_CNT, 32'h2, 32'h2},
			'{`ETC_OFF_ENTRY_LO, 32'h40, 32'h40},
			'{`ETC_OFF_FS_LO, 32'h3000, 32'h3000},
			'{`ETC_OFF_GS_LO, 32'h5000, 32'h5000},
			'{`ETC_OFF_FS_LIM, 32'hfff, 32'hfff},
			'{`ETC_OFF_GS_LIM, 32'h1fff, 32'h1fff},
			'{`ETC_OFF_CONTAINER_LO, 32'h10000, 32'h10000},
			'{`ETC_OFF_FLAGS_LO, 32'h1, 32'h1},
			'{`ETC_OFF_CUR_IDX, 32'h5, 32'h0},
			'{`ETC_OFF_AEP_LO, 32'h1234, 32'h0},
			'{`ETC_OFF_BUSY_LO, 32'h1, 32'h0},
			'{12'h100, 32'hdead, 32'h0}};
		repeat (12) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		rdc("frame count", `ETC_OFF_FRM_CNT, 32'h1);
		rdc("index", `ETC_OFF_CUR_IDX, 32'h0);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rdc("register", rows[i].a, rows[i].e);
		end
		hsel <= 1'b0;
		wr(`ETC_OFF_FRM_CNT, 32'h3);
		hsel <= 1'b1;
		rdc("deselected", `ETC_OFF_FRM_CNT, 32'h2);
		i_aep <= 64'h0000_0007_0000_0abc;
		op(etc_pkg::ETC_OP_ENTER, 1'b0);
		chk("busy", 64'h1, {63'h0, busy});
		chk("target", 64'h10040, tip);
		chk("fs base", 64'h13000, fsb);
		chk("gs base", 64'h15000, gsb);
		chk("fs limit", 64'hfff, {32'h0, fsl});
		chk("gs limit", 64'h1fff, {32'h0, gsl});
		chk("debug", 64'h1, {63'h0, dbg});
		rdc("exit ptr", `ETC_OFF_AEP_LO, 32'habc);
		rdc("exit ptr hi", `ETC_OFF_AEP_HI, 32'h7);
		chk("hresp", 64'h0, {63'h0, hresp});
		op(etc_pkg::ETC_OP_ENTER, 1'b1);
		op(etc_pkg::ETC_OP_AEX, 1'b0);
		chk("frame", 64'h12000, frm);
		chk("exit target", 64'h7_0000_0abc, tip);
		chk("debug off", 64'h0, {63'h0, dbg});
		chk("misc", 64'h10, {48'h0, misc});
		chk("save fault", 64'h1, {63'h0, save_f});
		rdc("index", `ETC_OFF_CUR_IDX, 32'h1);
		op(etc_pkg::ETC_OP_RESUME, 1'b0);
		rdc("index", `ETC_OFF_CUR_IDX, 32'h0);
		op(etc_pkg::ETC_OP_AEX, 1'b0);
		op(etc_pkg::ETC_OP_ENTER, 1'b0);
		op(etc_pkg::ETC_OP_AEX, 1'b0);
		chk("frame", 64'h13000, frm);
		op(etc_pkg::ETC_OP_ENTER, 1'b1);
		op(etc_pkg::ETC_OP_RESUME, 1'b1);
		op(etc_pkg::ETC_OP_PAGE_ADD, 1'b0);
		rdc("index", `ETC_OFF_CUR_IDX, 32'h0);
		rdc("flags", `ETC_OFF_FLAGS_LO, 32'h0);
		attr <= 1'b0;
		wr(`ETC_OFF_FLAGS_LO, 32'h1);
		rdc("flags locked", `ETC_OFF_FLAGS_LO, 32'h0);
		attr <= 1'b1;
		op(etc_pkg::ETC_OP_AEX, 1'b1);
		op(etc_pkg::ETC_OP_RESUME, 1'b1);
		op(etc_pkg::ETC_OP_ENTER, 1'b0);
		op(etc_pkg::ETC_OP_EXIT, 1'b0);
		chk("busy", 64'h0, {63'h0, busy});
		op(etc_pkg::ETC_OP_ENTER, 1'b0);
		op(etc_pkg::ETC_OP_AEX, 1'b0);
		op(etc_pkg::ETC_OP_PAGE_ACCEPT, 1'b0);
		rdc("index", `ETC_OFF_CUR_IDX, 32'h0);
		wr(`ETC_OFF_EXT_SEL, 32'h0);
		repeat (2) @(posedge i_clk);
		#1;
		chk("misc", 64'h0, {48'h0, misc});
		chk("save fault", 64'h0, {63'h0, save_f});
		@(posedge i_clk);
		op(etc_pkg::ETC_OP_ENTER, 1'b0);
		i_rst <= 1'b1;
		@(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		chk("busy", 64'h0, {63'h0, busy});
		rdc("frame count", `ETC_OFF_FRM_CNT, 32'h1);
		rdc("busy", `ETC_OFF_BUSY_LO, 32'h0);
		stop_test();
	end
endmodule
